// *** rtl/defs_defs.svh ***
/*
  Constants for the directional earth fault stage: sizes, setting-word field
  positions, event flag positions, fixed limits and timing figures.
  Assumes magnitudes in counts of 0.001 of nominal and angles in 1/4096 turn.
*/
`ifndef DEFS_DEFS_SVH
`define DEFS_DEFS_SVH
// Operation
// R1 - Four independent stage instances are provided.
// R2 - Residual current comes from coarse, sensitive or calculated input by setting.
// R3 - Magnitude is RMS, true RMS over 32 components, or peak-to-peak.
// R4 - Peak-to-peak is taken directly from raw samples.
// R5 - Direction compares residual current angle with neutral voltage angle.
// R6 - Angle is computed only while current and voltage exceed 0.01 nominal.
// R7 - No trip without enough neutral voltage.
// R8 - Eight setting groups per stage, chosen by one common selector.
// R9 - Blocking and group changes are accepted while the stage runs.
// R10 - Instant, definite time or inverse time operation.
// R11 - Order: input, magnitude, threshold, angle, block, delay, outputs.
// R12 - Timestamped ON and OFF events for start, trip and blocked.
// R13 - In instant mode start and trip events share one timestamp.
// R14 - Timestamps have one millisecond resolution.
// R15 - Cumulative counters for start, trip and blocked occurrences.
// R16 - The front end refreshes all magnitudes every five milliseconds.
// R17 - The front end offers a calculated neutral voltage alternative.
// R18 - Pre-fault value is a 20 ms average ending 20 ms before the event.
// R19 - Pick-up when residual current exceeds its threshold.
// R20 - Pick-up releases only below 97 percent of threshold.
// R21 - Input selection codes: 1 coarse, 2 sensitive, 3 calculated.
// R22 - Negated polarity setting inverts the voltage angle reference.
// R23 - Start when picked up and unblocked, otherwise blocked.
// R24 - Each instance keeps its own settings, outputs, counters and events.

`define DEFS_STAGES 4
`define DEFS_GROUPS 8
`define DEFS_MAG_W 20
`define DEFS_ANG_W 12
`define DEFS_SMP_W 16
`define DEFS_CNT_W 16
`define DEFS_TS_W 32
`define DEFS_ADDR_W 5
`define DEFS_TRMS_COMPONENTS 32

`define DEFS_CLK_PERIOD_NS 5
`define DEFS_TS_RES_NS 1000000

`define DEFS_SQUELCH_I 20'h0_000A
`define DEFS_SQUELCH_U 20'h0_000A
`define DEFS_RESET_PCT 27'h000_0061
`define DEFS_FULL_PCT 27'h000_0064
`define DEFS_HALF_TURN 12'h800

`define DEFS_HIST_N 7
`define DEFS_AVG_FIRST 3

`define DEFS_F_ITHR 0
`define DEFS_F_UTHR 20
`define DEFS_F_CTR 40
`define DEFS_F_HALF 52
`define DEFS_F_DLY 64
`define DEFS_F_MODE 84
`define DEFS_SET_W 86

`define DEFS_EV_START_ON 0
`define DEFS_EV_START_OFF 1
`define DEFS_EV_TRIP_ON 2
`define DEFS_EV_TRIP_OFF 3
`define DEFS_EV_BLK_ON 4
`define DEFS_EV_BLK_OFF 5
`define DEFS_EV_W 6
`endif

// *** rtl/defs_pkg.sv ***
/*
  Types of the directional earth fault stage: selector codes, modes and the
  settings sequencer state.
  Assumes the constants header is included by the files that need sizes.
*/
package defs_pkg;
  typedef enum logic [1:0] {
    DEFS_IN_NONE = 2'h0,
    DEFS_IN_COARSE = 2'h1,
    DEFS_IN_SENS = 2'h2,
    DEFS_IN_CALC = 2'h3
  } defs_input_t;
  typedef enum logic [1:0] {
    DEFS_MAG_NONE = 2'h0,
    DEFS_MAG_RMS = 2'h1,
    DEFS_MAG_TRMS = 2'h2,
    DEFS_MAG_PP = 2'h3
  } defs_mag_t;
  typedef enum logic [1:0] {
    DEFS_OP_INSTANT = 2'h0,
    DEFS_OP_DT = 2'h1,
    DEFS_OP_IDMT = 2'h2,
    DEFS_OP_SPARE = 2'h3
  } defs_op_t;
  typedef enum logic [0:0] {
    DEFS_SEQ_IDLE = 1'b0,
    DEFS_SEQ_RUN = 1'b1
  } defs_seq_t;
endpackage

// *** rtl/defs_set_mem.sv ***
/*
  Setting-group memory: one word per stage and group, registered read port.
  Assumes a single writer and reads issued by the stage sequencer.
*/
`timescale 1ns/1ps
`default_nettype none
`include "defs_defs.svh"
module defs_set_mem (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_wr_en,
  input wire logic [`DEFS_ADDR_W-1:0] i_wr_addr,
  input wire logic [`DEFS_SET_W-1:0] i_wr_data,
  input wire logic i_rd_en,
  input wire logic [`DEFS_ADDR_W-1:0] i_rd_addr,
  output logic [`DEFS_SET_W-1:0] o_rd_data,
  output logic o_rd_loaded
);
  logic [`DEFS_SET_W-1:0] mem [0:(1<<`DEFS_ADDR_W)-1];
  // Entries never written are reported unloaded so a stage stays idle on them.
  logic [(1<<`DEFS_ADDR_W)-1:0] loaded;

  always_ff @(posedge i_clock) begin
    if (i_wr_en) begin
      mem[i_wr_addr] <= i_wr_data;
    end
    if (i_rd_en) begin
      o_rd_data <= mem[i_rd_addr];
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      loaded <= '0;
      o_rd_loaded <= 1'b0;
    end else begin
      if (i_wr_en) begin
        loaded[i_wr_addr] <= 1'b1;
      end
      if (i_rd_en) begin
        o_rd_loaded <= loaded[i_rd_addr];
      end
    end
  end
endmodule
`default_nettype wire

// *** rtl/defs_pp_track.sv ***
/*
  Peak-to-peak tracker over raw samples, closed at each measurement window end.
  Assumes samples and window strobe come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "defs_defs.svh"
module defs_pp_track (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_sample_valid,
  input wire logic signed [`DEFS_SMP_W-1:0] i_sample,
  input wire logic i_window_end,
  output logic [`DEFS_MAG_W-1:0] o_pp
);
  logic signed [`DEFS_SMP_W-1:0] max_v;
  logic signed [`DEFS_SMP_W-1:0] min_v;
  logic signed [`DEFS_SMP_W+1:0] span;
  // An empty window has max below min, so the span is negative and reads zero.
  assign span = (`DEFS_SMP_W+2)'(max_v) - (`DEFS_SMP_W+2)'(min_v);

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      max_v <= 16'h8000;
      min_v <= 16'h7FFF;
      o_pp <= '0;
    end else if (i_window_end) begin
      o_pp <= span[`DEFS_SMP_W+1] ? '0 : `DEFS_MAG_W'(span); // [R4]
      max_v <= i_sample_valid ? i_sample : 16'h8000;
      min_v <= i_sample_valid ? i_sample : 16'h7FFF;
    end else if (i_sample_valid) begin
      if (i_sample > max_v) begin
        max_v <= i_sample;
      end
      if (i_sample < min_v) begin
        min_v <= i_sample;
      end
    end
  end
endmodule
`default_nettype wire

// *** rtl/defs_stage_top.sv ***
/*
  Directional earth fault stage, four instances sharing one measurement front
  end, one setting memory, one group selector and one millisecond time base.
  Assumes all inputs are produced by logic on i_clock and that magnitudes and
  angles are held stable between measurement strobes.
*/
`timescale 1ns/1ps
`default_nettype none
`include "defs_defs.svh"
module defs_stage_top #(
  parameter int unsigned MS_CYCLES = `DEFS_TS_RES_NS / `DEFS_CLK_PERIOD_NS
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_meas_valid,
  input wire logic [`DEFS_MAG_W-1:0] i_coarse_rms,
  input wire logic [`DEFS_MAG_W-1:0] i_coarse_trms,
  input wire logic [`DEFS_MAG_W-1:0] i_sens_rms,
  input wire logic [`DEFS_MAG_W-1:0] i_sens_trms,
  input wire logic [`DEFS_MAG_W-1:0] i_calc_residual_rms,
  input wire logic i_sample_valid,
  input wire logic signed [`DEFS_SMP_W-1:0] i_coarse_sample,
  input wire logic signed [`DEFS_SMP_W-1:0] i_sens_sample,
  input wire logic [`DEFS_ANG_W-1:0] i_coarse_angle,
  input wire logic [`DEFS_ANG_W-1:0] i_sens_angle,
  input wire logic [`DEFS_ANG_W-1:0] i_calc_residual_angle,
  input wire logic [`DEFS_MAG_W-1:0] i_neutral_voltage,
  input wire logic [`DEFS_ANG_W-1:0] i_neutral_angle,
  input wire logic [`DEFS_MAG_W-1:0] i_calc_neutral_voltage,
  input wire logic [`DEFS_ANG_W-1:0] i_calc_neutral_angle,
  input wire logic [2:0] i_setting_group,
  input wire logic i_set_wr_en,
  input wire logic [`DEFS_ADDR_W-1:0] i_set_wr_addr,
  input wire logic [`DEFS_SET_W-1:0] i_set_wr_data,
  input wire logic [2*`DEFS_STAGES-1:0] i_input_sel,
  input wire logic [2*`DEFS_STAGES-1:0] i_mag_mode,
  input wire logic [`DEFS_STAGES-1:0] i_polarity_neg,
  input wire logic [`DEFS_STAGES-1:0] i_use_calc_voltage,
  input wire logic [`DEFS_STAGES-1:0] i_block,
  output logic [`DEFS_STAGES-1:0] o_start,
  output logic [`DEFS_STAGES-1:0] o_trip,
  output logic [`DEFS_STAGES-1:0] o_blocked,
  output logic [`DEFS_STAGES-1:0] o_angle_valid,
  output logic [`DEFS_ANG_W*`DEFS_STAGES-1:0] o_fault_angle,
  output logic [`DEFS_STAGES-1:0] o_evt_valid,
  output logic [`DEFS_EV_W*`DEFS_STAGES-1:0] o_evt_flags,
  output logic [`DEFS_TS_W-1:0] o_evt_time,
  output logic [`DEFS_MAG_W*`DEFS_STAGES-1:0] o_evt_fault_mag,
  output logic [`DEFS_MAG_W*`DEFS_STAGES-1:0] o_evt_prefault,
  output logic [`DEFS_CNT_W*`DEFS_STAGES-1:0] o_start_count,
  output logic [`DEFS_CNT_W*`DEFS_STAGES-1:0] o_trip_count,
  output logic [`DEFS_CNT_W*`DEFS_STAGES-1:0] o_blocked_count
);
  localparam int unsigned MS_W = $clog2(MS_CYCLES + 1);

  // Millisecond time base shared by all stages and by the event timestamp.
  logic [MS_W-1:0] ms_div;
  logic ms_tick;
  logic [`DEFS_TS_W-1:0] ms_count;
  wire ms_wrap = (ms_div == MS_W'(MS_CYCLES - 1));

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      ms_div <= '0;
      ms_tick <= 1'b0;
      ms_count <= '0;
    end else begin
      ms_div <= ms_wrap ? '0 : ms_div + 1'b1;
      ms_tick <= ms_wrap;
      ms_count <= ms_count + `DEFS_TS_W'(ms_wrap); // [R14]
    end
  end

  // The timestamp flop is shared, so events of one cycle carry one time.
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_evt_time <= '0;
    end else begin
      o_evt_time <= ms_count; // [R13] [R14]
    end
  end

  logic [`DEFS_MAG_W-1:0] coarse_pp;
  logic [`DEFS_MAG_W-1:0] sens_pp;

  defs_pp_track u_coarse_pp (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_sample_valid(i_sample_valid),
    .i_sample(i_coarse_sample),
    .i_window_end(i_meas_valid),
    .o_pp(coarse_pp)
  );

  defs_pp_track u_sens_pp (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_sample_valid(i_sample_valid),
    .i_sample(i_sens_sample),
    .i_window_end(i_meas_valid),
    .o_pp(sens_pp)
  );

  // Sequencer fetches each stage's active group word once per measurement.
  defs_pkg::defs_seq_t seq_state;
  defs_pkg::defs_seq_t next_seq_state;
  logic [1:0] seq_idx;
  logic [1:0] eval_idx;
  logic eval_pulse;
  logic [`DEFS_SET_W-1:0] rd_data;
  logic rd_loaded;
  wire seq_rd = (seq_state == defs_pkg::DEFS_SEQ_RUN);
  wire [`DEFS_ADDR_W-1:0] seq_addr = {seq_idx, i_setting_group}; // [R8] [R9]

  always_comb begin
    case (seq_state)
      defs_pkg::DEFS_SEQ_IDLE: next_seq_state = i_meas_valid ? defs_pkg::DEFS_SEQ_RUN : defs_pkg::DEFS_SEQ_IDLE;
      defs_pkg::DEFS_SEQ_RUN: next_seq_state = (seq_idx == 2'h3) ? defs_pkg::DEFS_SEQ_IDLE : defs_pkg::DEFS_SEQ_RUN;
      default: next_seq_state = defs_pkg::DEFS_SEQ_IDLE;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      seq_state <= defs_pkg::DEFS_SEQ_IDLE;
      seq_idx <= 2'h0;
      eval_idx <= 2'h0;
      eval_pulse <= 1'b0;
    end else begin
      seq_state <= next_seq_state;
      seq_idx <= seq_rd ? seq_idx + 2'h1 : 2'h0;
      eval_idx <= seq_idx;
      eval_pulse <= seq_rd;
    end
  end

  defs_set_mem u_set_mem (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_wr_en(i_set_wr_en),
    .i_wr_addr(i_set_wr_addr),
    .i_wr_data(i_set_wr_data),
    .i_rd_en(seq_rd),
    .i_rd_addr(seq_addr),
    .o_rd_data(rd_data),
    .o_rd_loaded(rd_loaded)
  );

  // Each stage keeps its own state; nothing below crosses between stages.
  for (genvar g = 0; g < `DEFS_STAGES; g++) begin : g_stage // [R1] [R24]
    wire [1:0] sel = i_input_sel[2*g +: 2];
    wire [1:0] mmode = i_mag_mode[2*g +: 2];
    wire eval = eval_pulse && (eval_idx == 2'(g));

    // Input selection and magnitude processing.
    wire [`DEFS_MAG_W-1:0] coarse_mag = (mmode == defs_pkg::DEFS_MAG_PP) ? coarse_pp :
      (mmode == defs_pkg::DEFS_MAG_TRMS) ? i_coarse_trms : i_coarse_rms; // [R3] [R4]
    wire [`DEFS_MAG_W-1:0] sens_mag = (mmode == defs_pkg::DEFS_MAG_PP) ? sens_pp :
      (mmode == defs_pkg::DEFS_MAG_TRMS) ? i_sens_trms : i_sens_rms; // [R3] [R4]
    wire sel_ok = (sel != defs_pkg::DEFS_IN_NONE);
    wire [`DEFS_MAG_W-1:0] mag = (sel == defs_pkg::DEFS_IN_CALC) ? i_calc_residual_rms :
      (sel == defs_pkg::DEFS_IN_SENS) ? sens_mag : coarse_mag; // [R2] [R21]
    wire [`DEFS_ANG_W-1:0] res_ang = (sel == defs_pkg::DEFS_IN_CALC) ? i_calc_residual_angle :
      (sel == defs_pkg::DEFS_IN_SENS) ? i_sens_angle : i_coarse_angle; // [R2] [R21]
    wire [`DEFS_MAG_W-1:0] umag = i_use_calc_voltage[g] ? i_calc_neutral_voltage : i_neutral_voltage;
    wire [`DEFS_ANG_W-1:0] uang = i_use_calc_voltage[g] ? i_calc_neutral_angle : i_neutral_angle;

    // Group settings as fetched this evaluation.
    wire [`DEFS_MAG_W-1:0] ithr = rd_data[`DEFS_F_ITHR +: `DEFS_MAG_W];
    wire [`DEFS_MAG_W-1:0] uthr = rd_data[`DEFS_F_UTHR +: `DEFS_MAG_W];
    wire [`DEFS_ANG_W-1:0] ctr = rd_data[`DEFS_F_CTR +: `DEFS_ANG_W];
    wire [`DEFS_ANG_W-1:0] half = rd_data[`DEFS_F_HALF +: `DEFS_ANG_W];

    // Threshold comparison with the fixed 97 percent release ratio.
    wire i_over = (mag > ithr); // [R19]
    wire i_under = (27'(mag) * `DEFS_FULL_PCT) < (27'(ithr) * `DEFS_RESET_PCT); // [R20]
    wire u_over = (umag > uthr); // [R7]
    wire u_under = (27'(umag) * `DEFS_FULL_PCT) < (27'(uthr) * `DEFS_RESET_PCT); // [R7] [R20]

    // Angle check; the modulo arithmetic wraps the full turn for free.
    wire squelch_ok = (mag > `DEFS_SQUELCH_I) && (umag > `DEFS_SQUELCH_U); // [R6]
    wire [`DEFS_ANG_W-1:0] rel_ang = res_ang - uang + (i_polarity_neg[g] ? `DEFS_HALF_TURN : '0); // [R5] [R22]
    wire [`DEFS_ANG_W-1:0] off_ang = rel_ang - ctr;
    wire [`DEFS_ANG_W-1:0] abs_ang = off_ang[`DEFS_ANG_W-1] ? `DEFS_ANG_W'(-off_ang) : off_ang;
    wire angle_ok = squelch_ok && (abs_ang <= half); // [R5] [R6]

    logic pick;
    logic [`DEFS_SET_W-1:0] held;
    wire next_pick = rd_loaded && sel_ok && angle_ok &&
      (pick ? !(i_under || u_under) : (i_over && u_over)); // [R11] [R19] [R20] [R7]
    wire start_now = eval ? (next_pick && !i_block[g]) : o_start[g]; // [R23] [R9]
    wire blk_now = eval ? (next_pick && i_block[g]) : o_blocked[g]; // [R23]

    // Delay stage uses the fetched mode and delay at evaluation, otherwise the settings held since the last evaluation.
    defs_pkg::defs_op_t op;
    logic [`DEFS_MAG_W-1:0] dly_ms;
    logic [`DEFS_MAG_W-1:0] timer_ms;
    logic [2*`DEFS_MAG_W-1:0] idmt_acc;
    logic [`DEFS_MAG_W-1:0] hist [0:`DEFS_HIST_N-1];
    assign op = defs_pkg::defs_op_t'(eval ? rd_data[`DEFS_F_MODE +: 2] : held[`DEFS_F_MODE +: 2]);
    assign dly_ms = eval ? rd_data[`DEFS_F_DLY +: `DEFS_MAG_W] : held[`DEFS_F_DLY +: `DEFS_MAG_W];
    wire [`DEFS_MAG_W-1:0] hthr = held[`DEFS_F_ITHR +: `DEFS_MAG_W];
    wire [2*`DEFS_MAG_W-1:0] idmt_lim = (2*`DEFS_MAG_W)'(dly_ms) * (2*`DEFS_MAG_W)'(hthr);
    wire trip_now = start_now && ((op == defs_pkg::DEFS_OP_INSTANT) ||
      ((op == defs_pkg::DEFS_OP_DT) && (timer_ms >= dly_ms)) ||
      ((op == defs_pkg::DEFS_OP_IDMT) && (idmt_acc >= idmt_lim))); // [R10] [R13]

    // Pre-fault average of the four samples aged 20 to 35 ms.
    wire [`DEFS_MAG_W+1:0] pre_sum = (`DEFS_MAG_W+2)'(hist[`DEFS_AVG_FIRST]) +
      (`DEFS_MAG_W+2)'(hist[`DEFS_AVG_FIRST+1]) + (`DEFS_MAG_W+2)'(hist[`DEFS_AVG_FIRST+2]) +
      (`DEFS_MAG_W+2)'(hist[`DEFS_AVG_FIRST+3]);

    wire [`DEFS_EV_W-1:0] ev;
    assign ev[`DEFS_EV_START_ON] = start_now && !o_start[g];
    assign ev[`DEFS_EV_START_OFF] = !start_now && o_start[g];
    assign ev[`DEFS_EV_TRIP_ON] = trip_now && !o_trip[g];
    assign ev[`DEFS_EV_TRIP_OFF] = !trip_now && o_trip[g];
    assign ev[`DEFS_EV_BLK_ON] = blk_now && !o_blocked[g];
    assign ev[`DEFS_EV_BLK_OFF] = !blk_now && o_blocked[g];

    always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
        pick <= 1'b0;
        held <= '0;
        o_start[g] <= 1'b0;
        o_blocked[g] <= 1'b0;
        o_trip[g] <= 1'b0;
      end else begin
        if (eval) begin
          pick <= next_pick;
          held <= rd_data;
        end
        o_start[g] <= start_now; // [R23]
        o_blocked[g] <= blk_now; // [R23]
        o_trip[g] <= trip_now; // [R10] [R13]
      end
    end

    // A released start clears both delay integrators.
    always_ff @(posedge i_clock) begin
      if (i_sys_rst || !start_now) begin
        timer_ms <= '0;
        idmt_acc <= '0;
      end else begin
        if (ms_tick && (timer_ms != '1)) begin
          timer_ms <= timer_ms + 1'b1; // [R10]
        end
        if (eval && (mag > hthr)) begin
          idmt_acc <= idmt_acc + (2*`DEFS_MAG_W)'(mag - hthr); // [R10]
        end
      end
    end

    always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
        for (int k = 0; k < `DEFS_HIST_N; k++) begin
          hist[k] <= '0;
        end
        o_angle_valid[g] <= 1'b0;
        o_fault_angle[`DEFS_ANG_W*g +: `DEFS_ANG_W] <= '0;
      end else if (eval) begin
        hist[0] <= mag; // [R18]
        for (int k = 1; k < `DEFS_HIST_N; k++) begin
          hist[k] <= hist[k-1];
        end
        o_angle_valid[g] <= squelch_ok; // [R6]
        if (squelch_ok) begin
          o_fault_angle[`DEFS_ANG_W*g +: `DEFS_ANG_W] <= rel_ang; // [R6] [R22]
        end
      end
    end

    always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
        o_evt_valid[g] <= 1'b0;
        o_evt_flags[`DEFS_EV_W*g +: `DEFS_EV_W] <= '0;
        o_evt_fault_mag[`DEFS_MAG_W*g +: `DEFS_MAG_W] <= '0;
        o_evt_prefault[`DEFS_MAG_W*g +: `DEFS_MAG_W] <= '0;
        o_start_count[`DEFS_CNT_W*g +: `DEFS_CNT_W] <= '0;
        o_trip_count[`DEFS_CNT_W*g +: `DEFS_CNT_W] <= '0;
        o_blocked_count[`DEFS_CNT_W*g +: `DEFS_CNT_W] <= '0;
      end else begin
        o_evt_valid[g] <= |ev; // [R12]
        o_evt_flags[`DEFS_EV_W*g +: `DEFS_EV_W] <= ev; // [R12] [R13]
        if (ev[`DEFS_EV_START_ON] || ev[`DEFS_EV_TRIP_ON] || ev[`DEFS_EV_BLK_ON]) begin
          o_evt_fault_mag[`DEFS_MAG_W*g +: `DEFS_MAG_W] <= mag;
        end
        if (ev[`DEFS_EV_START_ON] || ev[`DEFS_EV_TRIP_ON]) begin
          o_evt_prefault[`DEFS_MAG_W*g +: `DEFS_MAG_W] <= pre_sum[`DEFS_MAG_W+1:2]; // [R18]
        end
        o_start_count[`DEFS_CNT_W*g +: `DEFS_CNT_W] <= o_start_count[`DEFS_CNT_W*g +: `DEFS_CNT_W] +
          `DEFS_CNT_W'(ev[`DEFS_EV_START_ON]); // [R15]
        o_trip_count[`DEFS_CNT_W*g +: `DEFS_CNT_W] <= o_trip_count[`DEFS_CNT_W*g +: `DEFS_CNT_W] +
          `DEFS_CNT_W'(ev[`DEFS_EV_TRIP_ON]); // [R15]
        o_blocked_count[`DEFS_CNT_W*g +: `DEFS_CNT_W] <= o_blocked_count[`DEFS_CNT_W*g +: `DEFS_CNT_W] +
          `DEFS_CNT_W'(ev[`DEFS_EV_BLK_ON]); // [R15]
      end
    end
  end
endmodule
`default_nettype wire

// *** test/defs_stage_assertions.sv ***
/*
  Port checks for the directional earth fault stage top.
  Assumes it is bound to defs_stage_top and runs on its single clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "defs_defs.svh"
module defs_stage_assertions (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_meas_valid,
  input wire logic [`DEFS_STAGES-1:0] i_block,
  input wire logic [`DEFS_STAGES-1:0] o_start,
  input wire logic [`DEFS_STAGES-1:0] o_trip,
  input wire logic [`DEFS_STAGES-1:0] o_blocked,
  input wire logic [`DEFS_STAGES-1:0] o_evt_valid,
  input wire logic [`DEFS_EV_W*`DEFS_STAGES-1:0] o_evt_flags,
  input wire logic [`DEFS_CNT_W*`DEFS_STAGES-1:0] o_start_count
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_sys_rst);
  start_blk_excl_a: assert property ((o_start & o_blocked) == 4'h0)
    else $error("start and blocked high together");
  trip_has_start_a: assert property (o_trip[0] |-> o_start[0])
    else $error("trip without start");
  start_on_evt_a: assert property ($rose(o_start[0]) |-> o_evt_valid[0] && o_evt_flags[0])
    else $error("start on event missing");
  start_off_evt_a: assert property ($fell(o_start[0]) |-> o_evt_valid[0] && o_evt_flags[1])
    else $error("start off event missing");
  blk_cause_a: assert property ($rose(o_blocked[0]) |-> $past(i_block[0]) && o_evt_flags[4])
    else $error("blocked without block input or event");
  flag_valid_a: assert property (o_evt_valid[0] == (o_evt_flags[5:0] != 6'h00))
    else $error("event valid and flags disagree");
  start_cnt_a: assert property ($rose(o_start[0]) |-> o_start_count[15:0] == $past(o_start_count[15:0]) + 16'h0001)
    else $error("start count did not step");
  eval_slot_a: assert property ($changed(o_start[0]) |-> $past(i_meas_valid, 3))
    else $error("start changed outside its evaluation slot");
endmodule
`default_nettype wire

// *** test/defs_front_model.sv ***
/*
  Measurement front-end model: one strobe per 5 ms frame, held magnitudes
  and alternating raw samples.
  Assumes the bench changes its targets well away from the strobe.
*/
`timescale 1ns/1ps
`default_nettype none
module defs_front_model #(
  parameter int unsigned PERIOD = 100
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic [19:0] i_cur,
  input wire logic [19:0] i_volt,
  input wire logic [11:0] i_ang,
  output logic o_meas_valid,
  output logic o_sample_valid,
  output logic [15:0] o_sample,
  output logic [19:0] o_cur = 20'h0_0000,
  output logic [19:0] o_volt = 20'h0_0000,
  output logic [11:0] o_ang = 12'h000
);
  logic [15:0] cnt = 16'h0000;
  // Values move ten clocks before the strobe, so the whole evaluation sweep sees them settled.
  always @(posedge i_clock) begin
    cnt <= (i_sys_rst || cnt == 16'(PERIOD - 1)) ? 16'h0000 : cnt + 16'h0001;
    if (cnt == 16'(PERIOD - 10)) begin
      o_cur <= i_cur;
      o_volt <= i_volt;
      o_ang <= i_ang;
    end
  end
  assign o_meas_valid = !i_sys_rst && cnt == 16'h0000;
  assign o_sample_valid = cnt[1:0] == 2'h0;
  assign o_sample = cnt[2] ? 16'h0008 : 16'hfff8;
endmodule
`default_nettype wire

// *** test/defs_tb.sv ***
/*
  Self-checking bench for the directional earth fault stage top.
  Assumes a shortened millisecond of 20 clocks, so one frame is 100 clocks.
*/
`timescale 1ns/1ps
`default_nettype none
`include "defs_defs.svh"
module tb;
  localparam int unsigned MS = 20;
  localparam logic [19:0] HI = 20'h0_0096;
  localparam logic [19:0] VN = 20'h0_00c8;
  logic clock = 1'b0, sys_rst = 1'b1, pol = 1'b0, ucv = 1'b0, blk = 1'b0, wr_en = 1'b0, pair = 1'b0;
  logic [1:0] sel = 2'h1, mode = 2'h1;
  logic [2:0] grp = 3'h0;
  logic [19:0] cur_t = 20'h0_0000, volt_t = 20'h0_0000, cur, volt;
  logic [11:0] ang_t = 12'h000, ang;
  logic [`DEFS_ADDR_W-1:0] wr_addr = 5'h00;
  logic [`DEFS_SET_W-1:0] wr_data = '0;
  logic mv, sv;
  logic [15:0] smp;
  logic [3:0] st, tr, bl, ev_v, av;
  logic [47:0] fa;
  logic [31:0] et, t0;
  logic [79:0] fm, pf;
  logic [63:0] sc, tc, bc;
  logic [23:0] ev_f;
  logic [5:0] ev_seen = 6'h00;
  int n_fail = 0, total_checks = 0, n_test = 0;
  initial begin
    forever #2.5 clock = ~clock;
  end
  defs_front_model #(.PERIOD(5 * MS)) u_front (.i_clock(clock), .i_sys_rst(sys_rst), .i_cur(cur_t),
    .i_volt(volt_t), .i_ang(ang_t), .o_meas_valid(mv), .o_sample_valid(sv), .o_sample(smp),
    .o_cur(cur), .o_volt(volt), .o_ang(ang));
  // Coarse TRMS, sensitive RMS and calculated voltage are scaled down, so using one in place of an unscaled source changes the outcome.
  defs_stage_top #(.MS_CYCLES(MS)) dut (.i_clock(clock), .i_sys_rst(sys_rst), .i_meas_valid(mv),
    .i_coarse_rms(cur), .i_coarse_trms(cur >> 1), .i_sens_rms(cur >> 2), .i_sens_trms(cur),
    .i_calc_residual_rms(cur), .i_sample_valid(sv), .i_coarse_sample(smp), .i_sens_sample(smp),
    .i_coarse_angle(ang), .i_sens_angle(ang), .i_calc_residual_angle(ang), .i_neutral_voltage(volt),
    .i_neutral_angle(12'h000), .i_calc_neutral_voltage(volt >> 2), .i_calc_neutral_angle(12'h000),
    .i_setting_group(grp), .i_set_wr_en(wr_en), .i_set_wr_addr(wr_addr), .i_set_wr_data(wr_data),
    .i_input_sel({4{sel}}), .i_mag_mode({4{mode}}), .i_polarity_neg({4{pol}}),
    .i_use_calc_voltage({4{ucv}}), .i_block({2'b01, 1'b0, blk}), .o_start(st), .o_trip(tr),
    .o_blocked(bl), .o_angle_valid(av), .o_fault_angle(fa), .o_evt_valid(ev_v), .o_evt_flags(ev_f),
    .o_evt_time(et), .o_evt_fault_mag(fm), .o_evt_prefault(pf), .o_start_count(sc), .o_trip_count(tc),
    .o_blocked_count(bc));
  always @(posedge clock) begin
    if (ev_v[0]) begin
      ev_seen <= ev_seen | ev_f[5:0];
      pair <= pair | (ev_f[0] & ev_f[2]);
    end
  end
  function automatic logic [`DEFS_SET_W-1:0] sw(input logic [19:0] ithr, uthr, input logic [1:0] md,
    input logic [19:0] dly);
    sw = {md, dly, 12'h200, 12'h000, uthr, ithr};
  endfunction
  task automatic chk(input string nm, input logic [15:0] e, g);
    total_checks++;
    if (e !== g) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [`DEFS_ADDR_W-1:0] a, input logic [`DEFS_SET_W-1:0] d);
    @(posedge clock);
    wr_en <= 1'b1;
    wr_addr <= a;
    wr_data <= d;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask
  task automatic wait_strobe();
    int i;
    i = 0;
    do begin
      @(posedge clock);
      i++;
    end while (!mv && i < 300);
    chk("strobe", 16'h0001, 16'(mv));
  endtask
  task automatic run(input logic [19:0] c, v, input logic pk, t);
    @(posedge clock);
    cur_t <= c;
    volt_t <= v;
    wait_strobe();
    repeat (8) @(posedge clock);
    chk("start", 16'(pk & !blk), 16'(st[0]));
    chk("blocked", 16'(pk & blk), 16'(bl[0]));
    chk("trip", 16'(t), 16'(tr[0]));
    chk("twin blocked", 16'(pk), 16'(bl[2]));
    chk("idle stage", 16'h0000, 16'(st[1]));
    n_test++;
    $display("test %0d done", n_test);
  endtask
  task automatic final_report();
    $display("checks %0d wrong %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (10000) @(posedge clock);
    n_fail++;
    final_report();
  end
  initial begin
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
    for (int s = 0; s <= 2; s += 2) begin
      wr({s[1:0], 3'h0}, sw(20'h0_0064, 20'h0_0064, 2'h0, 20'h0_0000));
      wr({s[1:0], 3'h1}, sw(20'h0_0000, 20'h0_0000, 2'h0, 20'h0_0000));
      wr({s[1:0], 3'h2}, sw(20'h0_0064, 20'h0_0064, 2'h1, 20'h0_0003));
      wr({s[1:0], 3'h3}, sw(20'h0_0064, 20'h0_0064, 2'h2, 20'h0_0001));
    end
    wait_strobe();
    run(HI, VN, 1'b1, 1'b1);
    mode <= 2'h2;
    run(HI, VN, 1'b0, 1'b0);
    sel <= 2'h2;
    mode <= 2'h1;
    run(HI, VN, 1'b0, 1'b0);
    mode <= 2'h2;
    run(HI, VN, 1'b1, 1'b1);
    sel <= 2'h3;
    run(HI, VN, 1'b1, 1'b1);
    sel <= 2'h1;
    mode <= 2'h3;
    run(HI, VN, 1'b0, 1'b0);
    sel <= 2'h0;
    mode <= 2'h1;
    run(HI, VN, 1'b0, 1'b0);
    sel <= 2'h1;
    run(20'h0_0064, VN, 1'b0, 1'b0);
    run(HI, VN, 1'b1, 1'b1);
    run(20'h0_0062, VN, 1'b1, 1'b1);
    t0 = et;
    run(20'h0_0060, VN, 1'b0, 1'b0);
    chk("time step", 16'h0005, 16'(et - t0));
    ang_t <= 12'h800;
    run(HI, VN, 1'b0, 1'b0);
    chk("fault angle", 16'h0800, 16'(fa[11:0]));
    pol <= 1'b1;
    run(HI, VN, 1'b1, 1'b1);
    chk("prefault", 16'h0068, pf[15:0]);
    pol <= 1'b0;
    ang_t <= 12'h000;
    ucv <= 1'b1;
    run(HI, VN, 1'b0, 1'b0);
    ucv <= 1'b0;
    blk <= 1'b1;
    run(HI, VN, 1'b1, 1'b0);
    blk <= 1'b0;
    run(HI, VN, 1'b1, 1'b1);
    grp <= 3'h1;
    run(HI, 20'h0_0014, 1'b1, 1'b1);
    run(HI, 20'h0_0005, 1'b0, 1'b0);
    chk("angle valid", 16'h0000, 16'(av[0]));
    run(20'h0_0005, VN, 1'b0, 1'b0);
    grp <= 3'h2;
    run(HI, VN, 1'b1, 1'b0);
    repeat (70) @(posedge clock);
    chk("delayed trip", 16'h0001, 16'(tr[0]));
    run(20'h0_0000, VN, 1'b0, 1'b0);
    chk("event kinds", 16'h003f, 16'(ev_seen));
    chk("instant pair", 16'h0001, 16'(pair));
    grp <= 3'h3;
    run(HI, VN, 1'b1, 1'b0);
    run(HI, VN, 1'b1, 1'b1);
    chk("fault mag", 16'h0096, fm[15:0]);
    chk("start count", 16'h0007, sc[15:0]);
    chk("trip count", 16'h0007, tc[15:0]);
    chk("blocked count", 16'h0001, bc[15:0]);
    chk("twin blocked count", 16'h0007, bc[47:32]);
    final_report();
  end
endmodule
bind defs_stage_top defs_stage_assertions u_chk (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
  .i_meas_valid(i_meas_valid), .i_block(i_block), .o_start(o_start), .o_trip(o_trip),
  .o_blocked(o_blocked), .o_evt_valid(o_evt_valid), .o_evt_flags(o_evt_flags),
  .o_start_count(o_start_count));
`default_nettype wire
